// ---- cra_consts.vh ----
// constants for the coherent read/write acknowledge master logic
`ifndef CRA_CONSTS_VH
`define CRA_CONSTS_VH
// read response field layout
`define CRA_RESP_W        4
`define CRA_RESP_LO_HI    1
`define CRA_RESP_LO_LO    0
`define CRA_DIRTY_BIT     2
`define CRA_SHARED_BIT    3
`define CRA_RESP_EXOKAY   2'h1
// read transaction type codes (user-side encoding)
`define CRA_TYPE_W        4
`define CRA_RD_NOSNOOP    4'h0
`define CRA_RD_ONCE       4'h1
`define CRA_RD_CLEAN      4'h2
`define CRA_RD_NSD        4'h3
`define CRA_RD_SHARED     4'h4
`define CRA_RD_UNIQUE     4'h5
`define CRA_CLEAN_UNIQUE  4'h6
`define CRA_MAKE_UNIQUE   4'h7
`define CRA_CLEAN_SHARED  4'h8
`define CRA_CLEAN_INVAL   4'h9
`define CRA_MAKE_INVAL    4'hA
`define CRA_BARRIER       4'hB
`define CRA_DVM           4'hC
// write response codes
`define CRA_WR_NOSNOOP    1'h1
// cache line state codes reported to the cache
`define CRA_LS_W          2
`define CRA_LS_UC         2'h0
`define CRA_LS_UD         2'h1
`define CRA_LS_SC         2'h2
`define CRA_LS_SD         2'h3
// violation flag bits
`define CRA_ERR_W         5
`define CRA_ERR_BURST     0
`define CRA_ERR_SHARED    1
`define CRA_ERR_DIRTY     2
`define CRA_ERR_LAST      3
`define CRA_ERR_EXOKAY    4
`endif

// ---- cra_master_ack.v ----
// master-side read/write acknowledge and coherent response tracking
`timescale 1ns/1ns
`include "cra_consts.vh"
module cra_master_ack #(
  parameter DATA_W = 32
) (
  input  wire                     sys_clk,
  input  wire                     rst_n,
  // read data channel from the interconnect
  input  wire                     rValid,
  input  wire [`CRA_RESP_W-1:0]   rResp,
  input  wire                     rLast,
  input  wire [DATA_W-1:0]        rData,
  output reg                      rReady,
  // type of the read whose beats are arriving, held by the user side
  input  wire [`CRA_TYPE_W-1:0]   rdType,
  // write response channel
  input  wire                     bValid,
  input  wire [1:0]               bResp,
  input  wire                     bNoSnoop,
  output reg                      bReady,
  // acknowledges
  output reg                      rAck,
  output reg                      wAck,
  // results toward the cache
  output reg                      lineValid,
  output reg  [`CRA_LS_W-1:0]     lineState,
  output reg                      writeBackDue,
  output reg  [DATA_W-1:0]        lineData,
  output reg  [`CRA_ERR_W-1:0]    errFlags
);

  // pins from the interconnect cross into sys_clk through two flops
  reg                   rValidS1, rValidS2;
  reg [`CRA_RESP_W-1:0] rRespS1, rRespS2;
  reg                   rLastS1, rLastS2;
  reg [DATA_W-1:0]      rDataS1, rDataS2;
  reg                   bValidS1, bValidS2;
  reg [1:0]             bRespS1, bRespS2;
  reg                   bNoSnoopS1, bNoSnoopS2;

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rValidS1   <= 1'b0;
      rValidS2   <= 1'b0;
      rRespS1    <= {`CRA_RESP_W{1'b0}};
      rRespS2    <= {`CRA_RESP_W{1'b0}};
      rLastS1    <= 1'b0;
      rLastS2    <= 1'b0;
      rDataS1    <= {DATA_W{1'b0}};
      rDataS2    <= {DATA_W{1'b0}};
      bValidS1   <= 1'b0;
      bValidS2   <= 1'b0;
      bRespS1    <= 2'h0;
      bRespS2    <= 2'h0;
      bNoSnoopS1 <= 1'b0;
      bNoSnoopS2 <= 1'b0;
    end else begin
      rValidS1   <= rValid;
      rValidS2   <= rValidS1;
      rRespS1    <= rResp;
      rRespS2    <= rRespS1;
      rLastS1    <= rLast;
      rLastS2    <= rLastS1;
      rDataS1    <= rData;
      rDataS2    <= rDataS1;
      bValidS1   <= bValid;
      bValidS2   <= bValidS1;
      bRespS1    <= bResp;
      bRespS2    <= bRespS1;
      bNoSnoopS1 <= bNoSnoop;
      bNoSnoopS2 <= bNoSnoopS1;
    end
  end

  // handshakes are judged on the synchronised view; ready toggles so each
  // beat is taken once despite the two-cycle sampling delay
  wire rBeat = rValidS2 & rReady;
  wire bBeat = bValidS2 & bReady;

  // dataless types complete in one beat and their data is junk
  reg  rdDataless;
  always @* begin
    case (rdType)
      `CRA_CLEAN_UNIQUE, `CRA_MAKE_UNIQUE, `CRA_CLEAN_SHARED,
      `CRA_CLEAN_INVAL, `CRA_MAKE_INVAL, `CRA_BARRIER, `CRA_DVM: begin
        rdDataless = 1'b1;
      end
      default: begin
        rdDataless = 1'b0;
      end
    endcase
  end

  // permitted shared/dirty pairs per transaction
  wire isShared = rRespS2[`CRA_SHARED_BIT];
  wire passDirty = rRespS2[`CRA_DIRTY_BIT];
  reg  sharedOk;
  reg  dirtyOk;
  reg  exOk;
  always @* begin
    sharedOk = 1'b0;
    dirtyOk  = 1'b0;
    exOk     = 1'b0;
    case (rdType)
      `CRA_RD_SHARED: begin
        sharedOk = 1'b1;
        dirtyOk  = 1'b1;
        exOk     = 1'b1;
      end
      `CRA_RD_NSD: begin
        sharedOk = ~passDirty;
        dirtyOk  = ~isShared;
      end
      `CRA_RD_UNIQUE: begin
        dirtyOk  = 1'b1;
      end
      `CRA_RD_ONCE, `CRA_CLEAN_SHARED: begin
        sharedOk = 1'b1;
      end
      `CRA_RD_CLEAN: begin
        sharedOk = 1'b1;
        exOk     = 1'b1;
      end
      `CRA_RD_NOSNOOP, `CRA_CLEAN_UNIQUE: begin
        exOk     = 1'b1;
      end
      default: begin
        exOk     = 1'b0; // both bits must be low
      end
    endcase
  end

  reg                   inBurst_q;
  reg [1:0]             burstResp_q;
  reg                   rReadyTgl_q;
  reg                   bReadyTgl_q;
  reg [`CRA_ERR_W-1:0]  errHit;
  wire [1:0]            beatResp   = {isShared, passDirty};
  wire                  beatExOkay = (rRespS2[`CRA_RESP_LO_HI:`CRA_RESP_LO_LO] == `CRA_RESP_EXOKAY);

  // ready drops for two cycles after a beat so a stale synchronised valid
  // is not taken twice; the price is one beat per three cycles at best
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rReady      <= 1'b0;
      rReadyTgl_q <= 1'b0;
    end else begin
      rReadyTgl_q <= rBeat;
      rReady      <= ~rBeat & ~rReadyTgl_q;
    end
  end

  // ack goes out the cycle after the last beat and is never held back;
  // acks follow last-beat order, so the interconnect needs no tag
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rAck      <= 1'b0;
      lineValid <= 1'b0;
    end else begin
      rAck      <= rBeat & rLastS2;
      lineValid <= rBeat & rLastS2;
    end
  end

  // burst tracking: coherent bits of the previous beat of this burst
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      inBurst_q   <= 1'b0;
      burstResp_q <= 2'h0;
    end else if (rBeat) begin
      inBurst_q   <= ~rLastS2;
      burstResp_q <= beatResp;
    end
  end

  // data capture: dataless beats carry junk, so the cache never sees it
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lineData <= {DATA_W{1'b0}};
    end else if (rBeat && !rdDataless) begin
      lineData <= rDataS2;
    end
  end

  // line state and write-back duty come from the final beat only
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lineState    <= `CRA_LS_UC;
      writeBackDue <= 1'b0;
    end else if (rBeat && rLastS2) begin
      lineState    <= beatResp;
      writeBackDue <= passDirty;
    end
  end

  // violations seen on the beat being taken this cycle
  always @* begin
    errHit = {`CRA_ERR_W{1'b0}};
    if (rBeat) begin
      if (inBurst_q && (burstResp_q != beatResp)) begin
        errHit[`CRA_ERR_BURST] = 1'b1;
      end
      if (!sharedOk && isShared) begin
        errHit[`CRA_ERR_SHARED] = 1'b1;
      end
      if (!dirtyOk && passDirty) begin
        errHit[`CRA_ERR_DIRTY] = 1'b1;
      end
      if (rdDataless && (!rLastS2 || inBurst_q)) begin
        errHit[`CRA_ERR_LAST] = 1'b1;
      end
      if (!exOk && beatExOkay) begin
        errHit[`CRA_ERR_EXOKAY] = 1'b1;
      end
    end
  end

  // flags are sticky until reset; nothing else clears them, so a
  // violation is never lost however briefly it appeared
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      errFlags <= {`CRA_ERR_W{1'b0}};
    end else begin
      errFlags <= errFlags | errHit;
    end
  end

  // write ready drops for two cycles after a response, like the read side
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bReady      <= 1'b0;
      bReadyTgl_q <= 1'b0;
    end else begin
      bReadyTgl_q <= bBeat;
      bReady      <= ~bBeat & ~bReadyTgl_q;
    end
  end

  // write side: accept responses in arrival order, ack each once
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wAck        <= 1'b0;
    end else begin
      // responses are consumed in delivery order, which already follows
      // address issue order per id, so acks pair up without tags
      wAck        <= bBeat;
      if (bBeat && !bNoSnoopS2 && (bRespS2 == `CRA_RESP_EXOKAY)) begin
        wAck <= 1'b1; // ack still sent for illegal response
      end
    end
  end

endmodule // cra_master_ack

// ---- cra_ack_checker.sv ----
// port checker for the coherent acknowledge master
`timescale 1ns/1ns
`include "cra_consts.vh"
module cra_ack_checker (
  input wire                   sys_clk,
  input wire                   rst_n,
  input wire                   rValid,
  input wire [`CRA_RESP_W-1:0] rResp,
  input wire                   rLast,
  input wire                   rReady,
  input wire                   bValid,
  input wire                   bReady,
  input wire                   rAck,
  input wire                   wAck,
  input wire                   lineValid,
  input wire [`CRA_LS_W-1:0]   lineState,
  input wire                   writeBackDue,
  input wire [`CRA_ERR_W-1:0]  errFlags
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // ready drops on the cycle after a beat is taken; the source lets valid
  // go as soon as it sees that, so the beat is looked at one edge back
  sequence s_lastTaken;
    $fell(rReady) && $past(rValid) && $past(rLast);
  endsequence
  sequence s_midTaken;
    $fell(rReady) && $past(rValid) && !$past(rLast);
  endsequence
  a_rack_on_last: assert property (s_lastTaken |-> rAck) else $error("read ack missing");
  a_rack_not_mid: assert property (s_midTaken |-> !rAck) else $error("read ack mid burst");
  a_rack_pulse: assert property (rAck |=> !rAck) else $error("read ack too long");
  a_wack_pulse: assert property (wAck |=> !wAck) else $error("write ack too long");
  a_wack_cause: assert property (wAck |-> $fell(bReady) && $past(bValid)) else $error("early write ack");
  a_wack_every: assert property ($fell(bReady) && $past(bValid) |-> wAck) else $error("write ack missing");
  a_line_state: assert property (rAck |-> lineValid && writeBackDue == $past(rResp[`CRA_DIRTY_BIT]) &&
    lineState == {$past(rResp[`CRA_SHARED_BIT]), $past(rResp[`CRA_DIRTY_BIT])}) else $error("line state wrong");
  a_err_sticky: assert property ((errFlags & $past(errFlags)) == $past(errFlags))
    else $error("flag lost");
endmodule // cra_ack_checker

// ---- cra_ic_model.sv ----
// behavioural interconnect: read beats and write responses
`timescale 1ns/1ns
module cra_ic_model (
  input  wire        sys_clk,
  output reg         rValid,
  output reg  [3:0]  rResp,
  output reg         rLast,
  output reg  [31:0] rData,
  input  wire        rReady,
  output reg         bValid,
  output reg  [1:0]  bResp,
  output reg         bNoSnoop,
  input  wire        bReady
);
  // idle lines at time zero
  initial begin
    {rValid, rResp, rLast, rData} = 38'h0;
    {bValid, bResp, bNoSnoop} = 4'h0;
  end
  // hold a beat until ready drops; released resp and data lines show the inverse, last keeps its value
  task beat(input [3:0] rs, input lst, input [31:0] d);
    begin
      rValid = 1'h1;
      rResp = rs;
      rLast = lst;
      rData = d;
      @(posedge sys_clk);
      #5;
      while (rReady !== 1'h0) begin
        @(posedge sys_clk);
        #5;
      end
      rValid = 1'h0;
      rResp = ~rs;
      rData = ~d;
      while (rReady !== 1'h1) begin
        @(posedge sys_clk);
        #5;
      end
    end
  endtask
  // responses go out in the caller's issue order
  task wresp(input [1:0] r, input ns);
    begin
      bValid = 1'h1;
      bResp = r;
      bNoSnoop = ns;
      @(posedge sys_clk);
      #5;
      while (bReady !== 1'h0) begin
        @(posedge sys_clk);
        #5;
      end
      bValid = 1'h0;
      bResp = ~r;
      bNoSnoop = ~ns;
      while (bReady !== 1'h1) begin
        @(posedge sys_clk);
        #5;
      end
    end
  endtask
endmodule // cra_ic_model

// ---- test_coherent_response_ack_logic.sv ----
// self-checking bench for the coherent acknowledge master
`timescale 1ns/1ns
`include "cra_consts.vh"
module test_coherent_response_ack_logic;
  reg         sys_clk, rst_n;
  reg  [3:0]  rdType;
  wire        rValid, rLast, rReady, bValid, bNoSnoop, bReady, rAck, wAck;
  wire        lineValid, writeBackDue;
  wire [3:0]  rResp;
  wire [31:0] rData, lineData;
  wire [1:0]  bResp, lineState;
  wire [4:0]  errFlags;
  integer     miscompares, checks, rAcks, wAcks, i;
  reg  [17:0] tbl [0:7];
  cra_master_ack #(.DATA_W(32)) i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .rValid(rValid),
    .rResp(rResp), .rLast(rLast), .rData(rData), .rReady(rReady), .rdType(rdType),
    .bValid(bValid), .bResp(bResp), .bNoSnoop(bNoSnoop), .bReady(bReady), .rAck(rAck),
    .wAck(wAck), .lineValid(lineValid), .lineState(lineState),
    .writeBackDue(writeBackDue), .lineData(lineData), .errFlags(errFlags));
  cra_ic_model i_ic (.sys_clk(sys_clk), .rValid(rValid), .rResp(rResp), .rLast(rLast),
    .rData(rData), .rReady(rReady), .bValid(bValid), .bResp(bResp), .bNoSnoop(bNoSnoop),
    .bReady(bReady));
  initial begin
    sys_clk = 1'h0;
    forever #25 sys_clk = ~sys_clk;
  end
  // ack pulses counted so a stretched or doubled pulse shows up
  always @(posedge sys_clk) begin
    if (rAck === 1'h1) rAcks = rAcks + 1;
    if (wAck === 1'h1) wAcks = wAcks + 1;
  end
  task check(input [31:0] seen, input [31:0] expd);
    begin
      checks = checks + 1;
      if (seen !== expd) begin
        miscompares = miscompares + 1;
        $display("[ERR] %0t seen %h expected %h", $time, seen, expd);
      end
    end
  endtask
  // sticky flags need a fresh reset per case
  task do_reset;
    begin
      rst_n = 1'h0;
      repeat (4) @(posedge sys_clk);
      #5 rst_n = 1'h1;
      rAcks = 0;
      wAcks = 0;
      @(posedge sys_clk);
      #5;
    end
  endtask
  // entry: type, first resp, final resp, two beats, expected flags
  task t_readTable;
    reg [17:0] e;
    begin
      for (i = 0; i < 8; i = i + 1) begin
        e = tbl[i];
        do_reset;
        rdType = e[17:14];
        if (e[5]) i_ic.beat(e[13:10], 1'h0, 32'h0000_00A5);
        i_ic.beat(e[9:6], 1'h1, 32'h5A5A_0F0F);
        repeat (3) @(posedge sys_clk);
        check(rAcks, 32'h1);
        check(lineState, e[9:8]);
        check(writeBackDue, e[8]);
        check(errFlags, e[4:0]);
        check(lineData, (e[17:14] >= `CRA_CLEAN_UNIQUE) ? 32'h0 : 32'h5A5A_0F0F);
      end
    end
  endtask
  // back-to-back responses, the second an exclusive okay without no-snoop
  task t_write;
    begin
      do_reset;
      i_ic.wresp(2'h1, 1'h1);
      i_ic.wresp(2'h1, 1'h0);
      repeat (3) @(posedge sys_clk);
      check(wAcks, 32'h2);
      check(errFlags, 32'h0);
    end
  endtask
  task give_verdict;
    begin
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  initial begin
    {rst_n, rdType, miscompares, checks, rAcks, wAcks} = 0;
    tbl[0] = {`CRA_RD_SHARED, 4'hC, 4'hC, 1'h1, 5'h00};
    tbl[1] = {`CRA_RD_SHARED, 4'h0, 4'hC, 1'h1, 5'h01};
    tbl[2] = {`CRA_CLEAN_UNIQUE, 4'h8, 4'h8, 1'h0, 5'h02};
    tbl[3] = {`CRA_RD_ONCE, 4'h4, 4'h4, 1'h0, 5'h04};
    tbl[4] = {`CRA_MAKE_INVAL, 4'h0, 4'h0, 1'h1, 5'h08};
    tbl[5] = {`CRA_DVM, 4'h1, 4'h1, 1'h0, 5'h10};
    tbl[6] = {`CRA_RD_NOSNOOP, 4'h1, 4'h1, 1'h0, 5'h00};
    tbl[7] = {`CRA_BARRIER, 4'h8, 4'h8, 1'h0, 5'h02};
    t_readTable;
    t_write;
    give_verdict;
  end
  // watchdog at 2000 cycles, well beyond the 150 or so cycles the cases need
  initial begin
    #100000;
    miscompares = miscompares + 1;
    give_verdict;
  end
endmodule // test_coherent_response_ack_logic
bind cra_master_ack cra_ack_checker i_chk (.sys_clk(sys_clk), .rst_n(rst_n), .rValid(rValid),
  .rResp(rResp), .rLast(rLast), .rReady(rReady), .bValid(bValid), .bReady(bReady),
  .rAck(rAck), .wAck(wAck), .lineValid(lineValid), .lineState(lineState),
  .writeBackDue(writeBackDue), .errFlags(errFlags));
